// file: src/wake_filter_pkg.sv
// Shared constants and carrier types for the wake frame filter and status block.
// Assumes a 32-bit register port with byte addresses and a byte-wide receive stream.
package wake_filter_pkg;

  localparam int NUM_FILTERS = 32;
  localparam int MASK_BITS = 128;
  localparam int NUM_ADDR_ENTRIES = 33;

  // Register byte addresses
  localparam logic [11:0] STATUS_OFS = 12'h144;
  localparam logic [11:0] CFG_FIRST_OFS = 12'h150;
  localparam logic [11:0] CFG_LAST_OFS = 12'h1CC;
  localparam logic [11:0] MASK_FIRST_OFS = 12'h200;
  localparam logic [11:0] MASK_LAST_OFS = 12'h3FC;
  localparam logic [11:0] ADDR_FIRST_OFS = 12'h400;
  localparam logic [11:0] ADDR_LAST_OFS = 12'h504;

  // Wake cause status fields
  localparam int STS_ENGINE_BIT = 12;
  localparam int STS_OWN_BIT = 11;
  localparam int STS_MAGIC_BIT = 10;
  localparam int STS_BCAST_BIT = 9;
  localparam int STS_PATTERN_BIT = 8;
  localparam int STS_INDEX_LSB = 0;
  localparam int STS_INDEX_W = 5;

  // Filter configuration fields
  localparam int CFG_EN_BIT = 31;
  localparam int CFG_TYPE_LSB = 24;
  localparam int CFG_OFFSET_LSB = 16;
  localparam int CFG_CRC_LSB = 0;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h83FF_FFFF;

  // Perfect address entry fields
  localparam int ADR_VALID_BIT = 31;
  localparam int ADR_SRC_BIT = 30;

  // CRC engine
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8005;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [8:0] POS_MAX = 9'h1FF;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } rx_beat_t;

  typedef struct packed {
    logic good;
    logic magic;
  } rx_end_t;

  typedef struct packed {
    logic filterEngine;
    logic ownAddress;
    logic magic;
    logic broadcast;
    logic pattern;
  } wake_enable_t;

  typedef struct packed {
    logic valid;
    logic isSource;
    logic [47:0] address;
  } addr_entry_t;

endpackage

// file: src/wake_frame_filter_status.sv
// Receive-side wake detection: 32 CRC-16 pattern filters, perfect address table,
// and the sticky wake cause status register.
// Assumes the receive path delivers one byte per beat with first/last marks on the clock.
//
// What this block does
// - Set status bit 12 when a good frame passes the perfect filters and wakes.
// - Set status bit 11 when a valid frame's destination equals our address and wakes.
// - Set status bit 10 when a valid magic packet wakes the device.
// - Set status bit 9 when a valid broadcast frame wakes the device.
// - Set status bit 8 when a valid frame matches a pattern filter and wakes.
// - Record matching filter index in status bits 4:0, valid while bit 8 set.
// - Provide 32 pattern filters, each spanning up to 128 frame bytes.
// - Configuration bit 31 enables a filter; a disabled filter never matches.
// - Type 00 unicast only, 10 multicast only, bit 24 set means all frames.
// - Offset field 23:16 picks the first checked byte; zero is destination start.
// - CRC-16 over masked bytes equal to bits 15:0 means a pattern match.
// - Mask bit j set includes byte offset plus j; clear skips it.
// - The 128-bit mask is four ascending words, word 0 holding bits 31:0.
// - Reset restores filter 0 configuration and mask from the loaded image.
// - A perfect entry takes part in matching only while its valid bit is set.
// - Entry bit 30 selects source address matching, else destination address.
// - Entry word 0 bits 15:0 hold address 47:32, word 1 holds 31:0.
// - A frame meeting several wake conditions sets every matching status bit.
// - Ignore wake events while entering suspend or after waking has begun.
// - Wake status bits stay set until software clears them.
`timescale 1ns/100ps
module wake_frame_filter_status #(
  parameter int NUM_FILTERS = wake_filter_pkg::NUM_FILTERS,
  parameter int NUM_ADDR_ENTRIES = wake_filter_pkg::NUM_ADDR_ENTRIES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire wake_filter_pkg::rx_beat_t rxBeat,
  input wire wake_filter_pkg::rx_end_t rxEnd,
  input wire logic [47:0] physAddress,
  input wire wake_filter_pkg::wake_enable_t wakeEnable,
  input wire logic wakeArmed,
  input wire logic [31:0] filter0ConfigImage,
  input wire logic [127:0] filter0MaskImage,
  output logic wakeSignal,
  output logic [31:0] wakeCauseStatus
);

  function automatic logic [15:0] crc16Next(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int b = 0; b < 8; b++) begin
      if (c[15] ^ data[7 - b]) begin
        c = {c[14:0], 1'b0} ^ wake_filter_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic addrTypeOk(input logic [1:0] kind, input logic multicast);
    logic ok;
    ok = 1'b0;
    if (kind[0]) begin
      ok = 1'b1;
    end else if (kind[1]) begin
      ok = multicast;
    end else begin
      ok = !multicast;
    end
    return ok;
  endfunction

  // Storage
  logic [31:0] cfg_r [NUM_FILTERS];
  logic [127:0] mask_r [NUM_FILTERS];
  wake_filter_pkg::addr_entry_t entry_r [NUM_ADDR_ENTRIES];
  logic [15:0] crc_r [NUM_FILTERS];
  logic [15:0] crc_nxt [NUM_FILTERS];
  logic [8:0] pos_r;
  logic [47:0] dst_r;
  logic [47:0] src_r;
  logic eval_r;
  wake_filter_pkg::rx_end_t end_r;
  logic [4:0] flags_r;
  logic [4:0] index_r;
  logic wakeSignal_r;
  logic [31:0] rdata_r;

  // Register decode
  wire isStatus = regAddr == wake_filter_pkg::STATUS_OFS;
  wire isCfg = regAddr >= wake_filter_pkg::CFG_FIRST_OFS
               && regAddr <= wake_filter_pkg::CFG_LAST_OFS;
  wire isMask = regAddr >= wake_filter_pkg::MASK_FIRST_OFS
                && regAddr <= wake_filter_pkg::MASK_LAST_OFS;
  wire isAddr = regAddr >= wake_filter_pkg::ADDR_FIRST_OFS
                && regAddr <= wake_filter_pkg::ADDR_LAST_OFS;
  wire aligned = regAddr[1:0] == 2'b00;
  wire [11:0] cfgRel = regAddr - wake_filter_pkg::CFG_FIRST_OFS;
  wire [11:0] addrRel = regAddr - wake_filter_pkg::ADDR_FIRST_OFS;
  wire [4:0] cfgIdx = cfgRel[6:2];
  wire [4:0] maskIdx = regAddr[8:4];
  wire [1:0] maskWord = regAddr[3:2];
  wire [5:0] addrIdx = addrRel[8:3];
  wire addrWord = regAddr[2];
  wire cfgWr = regWrite && aligned && isCfg;
  wire maskWr = regWrite && aligned && isMask;
  wire addrWr = regWrite && aligned && isAddr;
  wire statusWr = regWrite && aligned && isStatus;

  // Receive byte position
  wire [8:0] curPos = rxBeat.first ? 9'h000 : pos_r;
  wire [8:0] posNxt = (curPos == wake_filter_pkg::POS_MAX) ? curPos : curPos + 9'h001;

  // Per-filter byte selection and CRC step
  always_comb begin
    for (int f = 0; f < NUM_FILTERS; f++) begin
      logic [9:0] rel;
      logic [7:0] ofs;
      logic inWindow;
      logic [15:0] base;
      rel = 10'h000;
      ofs = cfg_r[f][wake_filter_pkg::CFG_OFFSET_LSB +: 8];
      rel = {1'b0, curPos} - {2'b00, ofs};
      inWindow = curPos >= {1'b0, ofs} && rel < 10'h080;
      base = rxBeat.first ? wake_filter_pkg::CRC_INIT : crc_r[f];
      if (rxBeat.valid && inWindow && mask_r[f][rel[6:0]]) begin
        crc_nxt[f] = crc16Next(base, rxBeat.data);
      end else begin
        crc_nxt[f] = rxBeat.valid ? base : crc_r[f];
      end
    end
  end

  // Frame end evaluation, one cycle after the last byte
  wire multicastDst = dst_r[0];
  wire broadcastDst = &dst_r;
  logic [NUM_FILTERS-1:0] filterHit;
  logic [NUM_ADDR_ENTRIES-1:0] entryHit;
  logic [4:0] hitIdx;

  always_comb begin
    for (int f = 0; f < NUM_FILTERS; f++) begin
      filterHit[f] = cfg_r[f][wake_filter_pkg::CFG_EN_BIT]
        && addrTypeOk(cfg_r[f][wake_filter_pkg::CFG_TYPE_LSB +: 2], multicastDst)
        && crc_r[f] == cfg_r[f][wake_filter_pkg::CFG_CRC_LSB +: 16];
    end
  end

  // Lowest numbered hit wins the index
  always_comb begin
    hitIdx = 5'h00;
    for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
      if (filterHit[f]) begin
        hitIdx = 5'(f);
      end
    end
  end

  always_comb begin
    for (int e = 0; e < NUM_ADDR_ENTRIES; e++) begin
      entryHit[e] = entry_r[e].valid
        && entry_r[e].address == (entry_r[e].isSource ? src_r : dst_r);
    end
  end

  // Only good frames while armed may wake; late events are dropped, not queued
  wire wakeWindow = eval_r && end_r.good && wakeArmed;
  wire [4:0] causeSet = {5{wakeWindow}} & {
    wakeEnable.filterEngine && (|entryHit),
    wakeEnable.ownAddress && dst_r == physAddress,
    wakeEnable.magic && end_r.magic,
    wakeEnable.broadcast && broadcastDst,
    wakeEnable.pattern && (|filterHit)
  };
  wire [4:0] causeClr = statusWr ? regWdata[wake_filter_pkg::STS_PATTERN_BIT +: 5] : 5'h00;
  wire indexClr = statusWr && (|regWdata[wake_filter_pkg::STS_INDEX_LSB +: 5]);
  // Set beats clear so a wake landing on a software clear survives
  wire [4:0] flags_nxt = (flags_r & ~causeClr) | causeSet;
  wire [4:0] index_nxt = causeSet[0] ? hitIdx : (indexClr ? 5'h00 : index_r);

  wire [31:0] statusWord = {19'h0, flags_r, 3'h0, index_r};

  // Read mux
  wire [31:0] maskRead = mask_r[maskIdx][32 * maskWord +: 32];
  wire [31:0] entryRead = addrWord ? entry_r[addrIdx].address[31:0]
    : {entry_r[addrIdx].valid, entry_r[addrIdx].isSource, 14'h0000,
       entry_r[addrIdx].address[47:32]};
  wire [31:0] readValue = !aligned ? 32'h0000_0000
    : isStatus ? statusWord
    : isCfg ? cfg_r[cfgIdx]
    : isMask ? maskRead
    : isAddr ? entryRead
    : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pos_r <= 9'h000;
      eval_r <= 1'b0;
      end_r <= '0;
      dst_r <= 48'h0;
      src_r <= 48'h0;
    end else begin
      if (rxBeat.valid) begin
        pos_r <= posNxt;
        if (curPos < 9'h006) begin
          dst_r[8 * curPos[2:0] +: 8] <= rxBeat.data;
        end else if (curPos < 9'h00C) begin
          src_r[8 * 3'(curPos - 9'h006) +: 8] <= rxBeat.data;
        end
      end
      eval_r <= rxBeat.valid && rxBeat.last;
      if (rxBeat.valid && rxBeat.last) begin
        end_r <= rxEnd;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int f = 0; f < NUM_FILTERS; f++) begin
      crc_r[f] <= reset ? wake_filter_pkg::CRC_INIT : crc_nxt[f];
    end
  end

  // Filter 0 comes back to the loaded image, the rest to zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int f = 0; f < NUM_FILTERS; f++) begin
        cfg_r[f] <= wake_filter_pkg::RESET_WORD;
        mask_r[f] <= {4{wake_filter_pkg::RESET_WORD}};
      end
      cfg_r[0] <= filter0ConfigImage & wake_filter_pkg::CFG_WRITE_MASK;
      mask_r[0] <= filter0MaskImage;
    end else begin
      if (cfgWr) begin
        cfg_r[cfgIdx] <= regWdata & wake_filter_pkg::CFG_WRITE_MASK;
      end
      if (maskWr) begin
        mask_r[maskIdx][32 * maskWord +: 32] <= regWdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int e = 0; e < NUM_ADDR_ENTRIES; e++) begin
        entry_r[e] <= '0;
      end
    end else if (addrWr) begin
      if (addrWord) begin
        entry_r[addrIdx].address[31:0] <= regWdata;
      end else begin
        entry_r[addrIdx].valid <= regWdata[wake_filter_pkg::ADR_VALID_BIT];
        entry_r[addrIdx].isSource <= regWdata[wake_filter_pkg::ADR_SRC_BIT];
        entry_r[addrIdx].address[47:32] <= regWdata[15:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_r <= 5'h00;
      index_r <= 5'h00;
      wakeSignal_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      flags_r <= flags_nxt;
      index_r <= index_nxt;
      wakeSignal_r <= |causeSet;
      rdata_r <= regRead ? readValue : 32'h0000_0000;
    end
  end

  assign regRdata = rdata_r;
  assign wakeSignal = wakeSignal_r;
  assign wakeCauseStatus = statusWord;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  engineSet_a: assert property (eval_r && end_r.good && wakeArmed
      && wakeEnable.filterEngine && (|entryHit) |=> flags_r[4])
    else $error("engine wake not recorded");
  ownSet_a: assert property (wakeWindow && wakeEnable.ownAddress
      && dst_r == physAddress |=> flags_r[3]) else $error("own address wake not recorded");
  magicSet_a: assert property (wakeWindow && wakeEnable.magic && end_r.magic
      |=> flags_r[2] && wakeSignal) else $error("magic wake not recorded");
  bcastSet_a: assert property (wakeWindow && wakeEnable.broadcast && (&dst_r)
      |=> flags_r[1]) else $error("broadcast wake not recorded");
  patternIndex_a: assert property (wakeWindow && wakeEnable.pattern && (|filterHit)
      |=> flags_r[0] && index_r == $past(hitIdx))
    else $error("pattern index wrong");
  disabledFilter_a: assert property (filterHit[0] |-> cfg_r[0][31])
    else $error("disabled filter matched");
  armedGate_a: assert property (!(eval_r && end_r.good && wakeArmed)
      && !statusWr |=> flags_r == $past(flags_r)) else $error("status moved while unarmed");
  stickyStatus_a: assert property ($fell(flags_r[0]) |-> $past(statusWr)
      && $past(regWdata[8])) else $error("status cleared without software");
  readLatency_a: assert property (regRead && isStatus ##1 !statusWr [*1]
      |-> regRdata == $past(statusWord)) else $error("status read mismatch");
  // A pulse needs a cause inside an armed window one cycle earlier
  wakeCause_a: assert property (wakeSignal |-> $past(wakeWindow))
    else $error("wake pulse without cause");
  indexHeld_a: assert property (!causeSet[0] && !indexClr
      |=> index_r == $past(index_r))
    else $error("match index moved");
  crcIdle_a: assert property (!rxBeat.valid
      |=> crc_r[0] == $past(crc_r[0]))
    else $error("crc moved without data");
  // Read data stand for one cycle only, so idle reads must show zero
  readIdle_a: assert property (!regRead |=> regRdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  patternWake_c: cover property (eval_r ##1 flags_r[0]);
  multiCause_c: cover property (causeSet[0] && causeSet[1]);
  setOnClear_c: cover property (statusWr && (|causeSet));
  entryMatch_c: cover property (eval_r && (|entryHit));
  ownWake_c: cover property (causeSet[3]);

endmodule

// file: sim/rx_path_model.sv
// Receive path model: streams one frame byte per clock with first and last marks.
// Assumes the block samples beats and the end status on rising core_clk edges.
`timescale 1ns/100ps
module rx_path_model (
  input wire logic core_clk,
  output wake_filter_pkg::rx_beat_t rxBeat,
  output wake_filter_pkg::rx_end_t rxEnd
);
  initial begin
    rxBeat = '0;
    rxEnd = '0;
  end
  task automatic send(input logic [7:0] bytes[$], input logic good, input logic magic);
    for (int i = 0; i < bytes.size(); i++) begin
      @(posedge core_clk);
      rxBeat <= '{valid: 1'b1, first: i == 0, last: i == bytes.size() - 1, data: bytes[i]};
      // End status means something only on the last beat, so garble it elsewhere
      if (i == bytes.size() - 1) begin
        rxEnd <= '{good: good, magic: magic};
      end else begin
        rxEnd <= '{good: ~good, magic: ~magic};
      end
    end
    @(posedge core_clk);
    // Idle byte flips so a stale value never passes for data
    rxBeat <= '{valid: 1'b0, first: 1'b0, last: 1'b0, data: ~rxBeat.data};
    rxEnd <= '{good: ~good, magic: ~magic};
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the wake frame filter and status block.
// Assumes the receive path model and the package are compiled first.
`timescale 1ns/100ps
module tb_top;
  logic core_clk;
  logic reset;
  logic [11:0] regAddr;
  logic [31:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdata;
  wake_filter_pkg::rx_beat_t rxBeat;
  wake_filter_pkg::rx_end_t rxEnd;
  logic [47:0] physAddress;
  wake_filter_pkg::wake_enable_t wakeEnable;
  logic wakeArmed;
  logic [31:0] cfgImage;
  logic [127:0] maskImage;
  logic wakeSignal;
  logic [31:0] wakeCauseStatus;
  logic [31:0] expQ[$];
  logic [7:0] frm[$];
  logic rdPend = 1'b0;
  int errors = 0;
  int checks = 0;
  int wakes = 0;
  int cycles = 0;

  wake_frame_filter_status i_dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxBeat(rxBeat), .rxEnd(rxEnd), .physAddress(physAddress), .wakeEnable(wakeEnable),
    .wakeArmed(wakeArmed), .filter0ConfigImage(cfgImage), .filter0MaskImage(maskImage),
    .wakeSignal(wakeSignal), .wakeCauseStatus(wakeCauseStatus));
  rx_path_model i_src (.core_clk(core_clk), .rxBeat(rxBeat), .rxEnd(rxEnd));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read data is judged one cycle after the strobe, against the oldest note
  always @(posedge core_clk) begin
    if (rdPend) compare(regRdata, expQ.pop_front());
    rdPend <= regRead;
    if (wakeSignal === 1'b1) wakes++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back(exp);
    @(posedge core_clk);
    regRead <= 1'b0;
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] f[$], input int ofs,
                                        input logic [127:0] m);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int j = 0; j < 128; j++) begin
      if (m[j] && ofs + j < f.size()) begin
        for (int b = 7; b >= 0; b--) begin
          c = {c[14:0], 1'b0} ^ ((c[15] ^ f[ofs + j][b]) ? 16'h8005 : 16'h0000);
        end
      end
    end
    return c;
  endfunction

  function automatic void mk(input logic [47:0] da, input logic [47:0] sa);
    frm = {};
    for (int k = 0; k < 6; k++) frm.push_back(da[8 * k +: 8]);
    for (int k = 0; k < 6; k++) frm.push_back(sa[8 * k +: 8]);
    for (int k = 0; k < 148; k++) frm.push_back(8'($urandom));
  endfunction

  // Sends frm, then checks the status three times, the wake pulse, and the clear
  task automatic frame_chk(input logic good, input logic magic, input logic [31:0] exp);
    int w0;
    w0 = wakes;
    i_src.send(frm, good, magic);
    repeat (3) @(posedge core_clk);
    rd(12'h144, exp);
    compare(32'(wakes - w0), 32'(exp != 32'h0));
    compare(wakeCauseStatus, exp);
    repeat (8) @(posedge core_clk);
    rd(12'h144, exp);
    wr(12'h144, 32'h0000_1F1F);
    rd(12'h144, 32'h0);
  endtask

  initial begin
    logic [127:0] msk;
    logic [31:0] cfg;
    logic [47:0] da;
    logic [47:0] sa;
    int ofs;
    void'($urandom(34915));
    reset = 1'b1;
    regAddr = 12'h000;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    physAddress = 48'({$urandom, $urandom}) & 48'hFFFF_FFFF_FFFE;
    wakeEnable = '1;
    wakeArmed = 1'b1;
    cfgImage = $urandom;
    maskImage = {$urandom, $urandom, $urandom, $urandom};
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd(12'h150, cfgImage & 32'h83FF_FFFF);
    for (int w = 0; w < 4; w++) rd(12'h200 + 12'(4 * w), maskImage[32 * w +: 32]);
    rd(12'h154, 32'h0);
    rd(12'h600, 32'h0);
    rd(12'h151, 32'h0);
    // Random filter 0 image could otherwise match a test frame
    wr(12'h150, 32'h0);
    msk = {$urandom, $urandom, $urandom, $urandom};
    for (int w = 0; w < 4; w++) begin
      wr(12'h230 + 12'(4 * w), msk[32 * w +: 32]);
      wr(12'h250 + 12'(4 * w), msk[32 * w +: 32]);
    end
    for (int w = 0; w < 4; w++) rd(12'h250 + 12'(4 * w), msk[32 * w +: 32]);
    ofs = $urandom_range(0, 15);
    da = 48'({$urandom, $urandom}) & 48'hFFFF_FFFF_FFFE;
    sa = 48'({$urandom, $urandom}) & 48'hFFFF_FFFF_FFFE;
    mk(da, sa);
    cfg = {1'b1, 5'h1F, 2'b01, 8'(ofs), crc16(frm, ofs, msk)};
    wr(12'h15C, cfg & 32'h7FFF_FFFF);
    wr(12'h164, cfg);
    rd(12'h164, cfg & 32'h83FF_FFFF);
    frame_chk(1'b1, 1'b0, 32'h0000_0105);
    frame_chk(1'b0, 1'b0, 32'h0);
    wakeArmed <= 1'b0;
    frame_chk(1'b1, 1'b0, 32'h0);
    wakeArmed <= 1'b1;
    da[0] = 1'b1;
    for (int t = 0; t < 4; t++) begin
      mk(da, sa);
      wr(12'h164, {1'b1, 5'h0, 2'(t), 8'(ofs), crc16(frm, ofs, msk)});
      frame_chk(1'b1, 1'b0, (t == 0) ? 32'h0 : 32'h0000_0105);
    end
    mk(48'hFFFF_FFFF_FFFF, sa);
    wr(12'h164, {1'b1, 5'h0, 2'b01, 8'(ofs), crc16(frm, ofs, msk)});
    frame_chk(1'b1, 1'b0, 32'h0000_0305);
    wr(12'h164, 32'h0);
    mk(physAddress, sa);
    frame_chk(1'b1, 1'b0, 32'h0000_0800);
    da[0] = 1'b0;
    mk(da, sa);
    frame_chk(1'b1, 1'b1, 32'h0000_0400);
    wr(12'h414, sa[31:0]);
    wr(12'h410, {2'b11, 14'h3FFF, sa[47:32]});
    rd(12'h410, {2'b11, 14'h0, sa[47:32]});
    rd(12'h414, sa[31:0]);
    frame_chk(1'b1, 1'b0, 32'h0000_1000);
    wr(12'h410, 32'h0);
    wr(12'h410, {2'b10, 14'h0, sa[47:32]});
    frame_chk(1'b1, 1'b0, 32'h0);
    wr(12'h410, {2'b01, 14'h0, sa[47:32]});
    frame_chk(1'b1, 1'b0, 32'h0);
    wr(12'h150, 32'hFFFF_FFFF);
    wr(12'h204, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(12'h150, cfgImage & 32'h83FF_FFFF);
    rd(12'h204, maskImage[63:32]);
    rd(12'h410, 32'h0);
    repeat (4) @(posedge core_clk);
    compare(32'(expQ.size()), 32'h0);
    final_report();
  end
endmodule
